// File: hw/pfw_ctrl.sv
// Flash self-read and self-write controller with an AHB-Lite register slave
//
// Operation
// - Flash data word is data_low bits 7-0 plus data_high bits 5-0.
// - Word address is addr_low plus low four bits of addr_high.
// - Unimplemented bits of data_high, addr_high and control read zero.
// - Trim space pick set steers reads to calibration area; reads only.
// - Program allow bit permits write cycles; clear blocks all self-writes.
// - Write strobe starts a write; set-only; hardware clears when done.
// - Read strobe starts a one-cycle read; set-only; hardware clears it.
// - First instruction after read strobe runs; second is skipped for access.
// - Read data lands next cycle and holds until next read or write.
// - Writes work on aligned four-word blocks, never crossing a boundary.
// - Strobe on words 00-10 only fills buffer; word 11 commits buffer.
// - Sixteen-word row erase only when low address nibble is 0011.
// - Two cycles of setup after write strobe; software places two NOPs.
// - Core halts about 4 ms during erase/write; clocks keep running.
// - Program allow clears at power-up; writes refused during 72 ms timer.
// - Guard bits protect segments from self-writes but not external programming.
// - Code protect blocks writes arriving from external programming port.
// - Write request with trim space pick set performs no write.
// - Unlock key port has no storage and reads back zero.
`timescale 1ns/1ps
`include "pfw_regs.svh"

module pfw_ctrl #(
	parameter int unsigned ADDR_W = 12,
	parameter int unsigned DATA_W = 14,
	parameter int unsigned PWRUP_CYCLES = `PFW_PWRUP_MS * (`PFW_CLK_HZ / 1000),
	parameter int unsigned WRITE_CYCLES = `PFW_WRITE_US * (`PFW_CLK_HZ / 1000000)
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Configuration word
	input wire logic [1:0] block_guard_bits,
	input wire logic code_protect,
	// External serial programming port write request
	input wire logic ext_prog_wr,
	input wire logic [ADDR_W-1:0] ext_prog_addr,
	input wire logic [DATA_W-1:0] ext_prog_data,
	// Flash array
	output logic flash_rd,
	output logic flash_trim_space,
	output logic flash_erase,
	output logic flash_wr,
	output logic [ADDR_W-1:0] flash_addr,
	output logic [DATA_W-1:0] flash_wdata,
	input wire logic [DATA_W-1:0] flash_rdata,
	// Core pipeline
	output logic cpu_skip,
	output logic cpu_stall
);

	localparam int unsigned PW = $clog2(PWRUP_CYCLES + 1);
	localparam int unsigned HW = $clog2(WRITE_CYCLES + 1);

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// Guard bits to protected segment: 11 none, 10 lowest eighth, 01 lower half, 00 all
	function automatic logic guarded(input logic [1:0] g, input logic [ADDR_W-1:0] a);
		logic r;
		r = 1'b0;
		case (g)
			2'h3: r = 1'b0;
			2'h2: r = (a[ADDR_W-1:ADDR_W-3] == 3'h0);
			2'h1: r = ~a[ADDR_W-1];
			default: r = 1'b1;
		endcase
		return r;
	endfunction

	// Byte offset decode
	function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
		return (a[31:8] == 24'h000000) && (a[7:0] == ofs);
	endfunction

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] data_low_r;
	logic [5:0] data_high_r;
	logic [7:0] addr_low_r;
	logic [3:0] addr_high_r;
	logic trim_r;
	logic allow_r;
	logic wr_r;
	logic rd_r;
	logic refused_r;
	logic [DATA_W-1:0] buf_r [4];
	pfw_pkg::pfw_state_type state_r;
	pfw_pkg::pfw_key_type key_r;
	logic [1:0] idx_r;
	logic [HW-1:0] cnt_r;
	logic [PW-1:0] pwrup_r;
	logic [ADDR_W-1:0] row_r;

	// Bus phase registers
	logic wph_r;
	logic [7:0] wofs_r;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic bus_go;
	logic wr_go;
	logic [ADDR_W-1:0] cur_addr;
	logic [DATA_W-1:0] cur_data;
	logic pwrup_busy;
	logic w_ctl;
	logic w_key;
	logic strobe_ok;
	logic take_wr;
	logic take_rd;

	assign bus_go = hsel & hready & htrans[1];
	// Word assembled from both data bytes
	assign cur_data = {data_high_r, data_low_r};
	// Address from low byte and high nibble
	assign cur_addr = {addr_high_r, addr_low_r};
	assign pwrup_busy = (pwrup_r != PW'(0));
	assign wr_go = wph_r;
	assign w_ctl = wr_go & (wofs_r == `PFW_OFS_CONTROL);
	assign w_key = wr_go & (wofs_r == `PFW_OFS_UNLOCK);

	// Strobe taken only with allow in the same write, unlock, timer done, free segment
	// Trim pick set in the strobe write refuses it, no write at all
	assign strobe_ok = hwdata[`PFW_CTL_ALLOW] & (key_r == pfw_pkg::PFW_KEY_ARMED) & ~pwrup_busy
		& ~hwdata[`PFW_CTL_TRIM] & ~guarded(block_guard_bits, cur_addr) & (state_r == pfw_pkg::PFW_IDLE);
	// Write strobe without the conditions is dropped
	assign take_wr = w_ctl & hwdata[`PFW_CTL_WR] & strobe_ok;
	assign take_rd = w_ctl & hwdata[`PFW_CTL_RD] & ~hwdata[`PFW_CTL_WR]
		& (state_r == pfw_pkg::PFW_IDLE);

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------

	// Address phase capture for the following data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wph_r <= 1'b0;
			wofs_r <= `PFW_RESET_BYTE;
		end else begin
			wph_r <= bus_go & hwrite & (hsize == `PFW_HSIZE_WORD) & (haddr[31:8] == 24'h000000);
			wofs_r <= haddr[7:0];
		end
	end

	// Zero-wait, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Read data registered at address phase; unmapped reads zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (bus_go && !hwrite) begin
			hrdata <= 32'h00000000;
			if (hit(haddr, `PFW_OFS_DATA_LOW)) begin
				hrdata[7:0] <= data_low_r;
			end
			if (hit(haddr, `PFW_OFS_DATA_HIGH)) begin
				hrdata[5:0] <= data_high_r;
			end
			if (hit(haddr, `PFW_OFS_ADDR_LOW)) begin
				hrdata[7:0] <= addr_low_r;
			end
			if (hit(haddr, `PFW_OFS_ADDR_HIGH)) begin
				hrdata[3:0] <= addr_high_r;
			end
			if (hit(haddr, `PFW_OFS_CONTROL)) begin
				hrdata[`PFW_CTL_TRIM] <= trim_r;
				hrdata[`PFW_CTL_ALLOW] <= allow_r;
				hrdata[`PFW_CTL_WR] <= wr_r;
				hrdata[`PFW_CTL_RD] <= rd_r;
			end
			if (hit(haddr, `PFW_OFS_STATUS)) begin
				hrdata[`PFW_STA_PWRUP] <= pwrup_busy;
				hrdata[`PFW_STA_BUSY] <= (state_r != pfw_pkg::PFW_IDLE);
				hrdata[`PFW_STA_REFUSED] <= refused_r;
			end
			// Unlock port has no storage and reads zero
		end
	end

	// ----------------------------------------
	// Power-up timer
	// ----------------------------------------

	// Counts down after reset; writes refused while nonzero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwrup_r <= PW'(PWRUP_CYCLES);
		end else if (pwrup_busy) begin
			pwrup_r <= pwrup_r - PW'(1);
		end
	end

	// ----------------------------------------
	// Unlock sequence
	// ----------------------------------------

	// Armed only by 55h then AAh as the last two writes before the strobe
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			key_r <= pfw_pkg::PFW_KEY_NONE;
		end else if (wr_go) begin
			if (w_key && hwdata[7:0] == `PFW_KEY_FIRST) begin
				key_r <= pfw_pkg::PFW_KEY_HALF;
			end else if (w_key && hwdata[7:0] == `PFW_KEY_SECOND && key_r == pfw_pkg::PFW_KEY_HALF) begin
				key_r <= pfw_pkg::PFW_KEY_ARMED;
			end else begin
				key_r <= pfw_pkg::PFW_KEY_NONE;
			end
		end
	end

	// ----------------------------------------
	// Address and configuration bits
	// ----------------------------------------

	// Address bytes, trim pick and allow written by software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_low_r <= `PFW_RESET_BYTE;
			addr_high_r <= 4'h0;
			trim_r <= 1'b0;
			allow_r <= 1'b0;
		end else if (wr_go) begin
			if (wofs_r == `PFW_OFS_ADDR_LOW) begin
				addr_low_r <= hwdata[7:0];
			end
			if (wofs_r == `PFW_OFS_ADDR_HIGH) begin
				addr_high_r <= hwdata[3:0];
			end
			if (w_ctl) begin
				trim_r <= hwdata[`PFW_CTL_TRIM];
				allow_r <= hwdata[`PFW_CTL_ALLOW];
			end
		end
	end

	// ----------------------------------------
	// Data bytes
	// ----------------------------------------

	// Read result wins over a software write in the same cycle, then holds
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_low_r <= `PFW_RESET_BYTE;
			data_high_r <= 6'h00;
		end else if (state_r == pfw_pkg::PFW_RD_ACCESS) begin
			data_low_r <= flash_rdata[7:0];
			data_high_r <= flash_rdata[DATA_W-1:8];
		end else if (wr_go) begin
			if (wofs_r == `PFW_OFS_DATA_LOW) begin
				data_low_r <= hwdata[7:0];
			end
			if (wofs_r == `PFW_OFS_DATA_HIGH) begin
				data_high_r <= hwdata[5:0];
			end
		end
	end

	// ----------------------------------------
	// Four-word write buffer
	// ----------------------------------------

	// Each accepted strobe loads its slot by low address bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 4; i++) begin
				buf_r[i] <= '0;
			end
		end else if (take_wr) begin
			buf_r[cur_addr[1:0]] <= cur_data;
		end
	end

	// ----------------------------------------
	// Strobe bits
	// ----------------------------------------

	// Set-only write strobe, cleared when commit or buffer load ends
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r <= 1'b0;
		end else if (take_wr) begin
			wr_r <= 1'b1;
		end else if (state_r == pfw_pkg::PFW_IDLE ||
			(state_r == pfw_pkg::PFW_WR_HOLD && cnt_r == HW'(0))) begin
			wr_r <= 1'b0;
		end
	end

	// Set-only read strobe, cleared after the access cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_r <= 1'b0;
		end else if (take_rd) begin
			rd_r <= 1'b1;
		end else if (state_r == pfw_pkg::PFW_RD_ACCESS) begin
			rd_r <= 1'b0;
		end
	end

	// Last write strobe refused; cleared by the next accepted one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			refused_r <= 1'b0;
		end else if (take_wr) begin
			refused_r <= 1'b0;
		end else if (w_ctl && hwdata[`PFW_CTL_WR]) begin
			refused_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------

	// Read timing, commit setup, erase, program and hold
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= pfw_pkg::PFW_IDLE;
			cnt_r <= HW'(0);
			idx_r <= 2'h0;
			row_r <= '0;
		end else begin
			case (state_r)
				pfw_pkg::PFW_IDLE: begin
					// Commit only from last word of a block
					if (take_wr && cur_addr[1:0] == `PFW_LAST_WORD) begin
						state_r <= pfw_pkg::PFW_WR_SETUP;
						cnt_r <= HW'(`PFW_SETUP_CYC - 1);
						row_r <= {cur_addr[ADDR_W-1:2], 2'h0};
					end else if (take_rd) begin
						state_r <= pfw_pkg::PFW_RD_WAIT;
					end
				end
				pfw_pkg::PFW_RD_WAIT: state_r <= pfw_pkg::PFW_RD_ACCESS;
				pfw_pkg::PFW_RD_ACCESS: state_r <= pfw_pkg::PFW_IDLE;
				// Two setup cycles before the halt
				pfw_pkg::PFW_WR_SETUP: begin
					if (cnt_r == HW'(0)) begin
						idx_r <= 2'h0;
						// Row erase only on nibble 0011
						if (addr_low_r[3:0] == `PFW_ERASE_NIBBLE) begin
							state_r <= pfw_pkg::PFW_WR_ERASE;
						end else begin
							state_r <= pfw_pkg::PFW_WR_PROG;
						end
					end else begin
						cnt_r <= cnt_r - HW'(1);
					end
				end
				pfw_pkg::PFW_WR_ERASE: state_r <= pfw_pkg::PFW_WR_PROG;
				pfw_pkg::PFW_WR_PROG: begin
					idx_r <= idx_r + 2'h1;
					if (idx_r == `PFW_LAST_WORD) begin
						state_r <= pfw_pkg::PFW_WR_HOLD;
						cnt_r <= HW'(WRITE_CYCLES - 1);
					end
				end
				// Core held for the write time
				pfw_pkg::PFW_WR_HOLD: begin
					if (cnt_r == HW'(0)) begin
						state_r <= pfw_pkg::PFW_IDLE;
					end else begin
						cnt_r <= cnt_r - HW'(1);
					end
				end
				default: state_r <= pfw_pkg::PFW_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Flash and core outputs
	// ----------------------------------------

	// Flash strobes, address and data, all registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flash_rd <= 1'b0;
			flash_trim_space <= 1'b0;
			flash_erase <= 1'b0;
			flash_wr <= 1'b0;
			flash_addr <= '0;
			flash_wdata <= '0;
		end else begin
			flash_rd <= (state_r == pfw_pkg::PFW_RD_WAIT);
			flash_erase <= 1'b0;
			flash_wr <= 1'b0;
			if (state_r == pfw_pkg::PFW_RD_WAIT) begin
				flash_addr <= cur_addr;
				// Calibration area chosen for reads only
				flash_trim_space <= trim_r;
			end else if (state_r == pfw_pkg::PFW_WR_SETUP && cnt_r == HW'(0)) begin
				// Erase pulse for the sixteen-word row
				flash_erase <= (addr_low_r[3:0] == `PFW_ERASE_NIBBLE);
				flash_addr <= {row_r[ADDR_W-1:4], 4'h0};
				flash_trim_space <= 1'b0;
			end else if (state_r == pfw_pkg::PFW_WR_ERASE) begin
				flash_addr <= row_r;
			end else if (state_r == pfw_pkg::PFW_WR_PROG) begin
				// Whole buffer goes to flash in address order
				flash_wr <= 1'b1;
				flash_addr <= {row_r[ADDR_W-1:2], idx_r};
				flash_wdata <= buf_r[idx_r];
			end else if (state_r == pfw_pkg::PFW_IDLE && ext_prog_wr && !code_protect) begin
				// Guard bits do not apply to external programming
				// Code protect blocks external programming writes
				flash_wr <= 1'b1;
				flash_addr <= ext_prog_addr;
				flash_wdata <= ext_prog_data;
				flash_trim_space <= 1'b0;
			end
		end
	end

	// Pipeline controls to the core
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_skip <= 1'b0;
			cpu_stall <= 1'b0;
		end else begin
			// Second instruction after read strobe is ignored
			cpu_skip <= (state_r == pfw_pkg::PFW_RD_WAIT);
			// Halt from end of setup until hold expires
			cpu_stall <= (state_r == pfw_pkg::PFW_WR_SETUP && cnt_r == HW'(0)) ||
				state_r == pfw_pkg::PFW_WR_ERASE || state_r == pfw_pkg::PFW_WR_PROG ||
				(state_r == pfw_pkg::PFW_WR_HOLD && cnt_r != HW'(0));
		end
	end

endmodule

// File: common/pfw_regs.svh
// Register offsets, field positions and timing figures of the flash self-write controller
`ifndef PFW_REGS_SVH
`define PFW_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PFW_OFS_DATA_LOW 8'h00
`define PFW_OFS_DATA_HIGH 8'h04
`define PFW_OFS_ADDR_LOW 8'h08
`define PFW_OFS_ADDR_HIGH 8'h0C
`define PFW_OFS_CONTROL 8'h10
`define PFW_OFS_UNLOCK 8'h14
`define PFW_OFS_STATUS 8'h18

// ----------------------------------------
// Fields
// ----------------------------------------
`define PFW_CTL_TRIM 6
`define PFW_CTL_ALLOW 2
`define PFW_CTL_WR 1
`define PFW_CTL_RD 0
`define PFW_STA_PWRUP 0
`define PFW_STA_BUSY 1
`define PFW_STA_REFUSED 2
`define PFW_KEY_FIRST 8'h55
`define PFW_KEY_SECOND 8'hAA
`define PFW_LAST_WORD 2'h3
`define PFW_ERASE_NIBBLE 4'h3
`define PFW_HSIZE_WORD 3'h2
`define PFW_RESET_BYTE 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define PFW_CLK_HZ 20000000
`define PFW_PWRUP_MS 72
`define PFW_WRITE_US 4000
`define PFW_SETUP_CYC 2

`endif

// File: common/pfw_pkg.sv
// Types shared by the flash self-write controller
package pfw_pkg;

	// Sequencer states, one-hot
	typedef enum logic [6:0] {
		PFW_IDLE = 7'h01,
		PFW_RD_WAIT = 7'h02,
		PFW_RD_ACCESS = 7'h04,
		PFW_WR_SETUP = 7'h08,
		PFW_WR_ERASE = 7'h10,
		PFW_WR_PROG = 7'h20,
		PFW_WR_HOLD = 7'h40
	} pfw_state_type;

	// Unlock key progress, one-hot
	typedef enum logic [2:0] {
		PFW_KEY_NONE = 3'h1,
		PFW_KEY_HALF = 3'h2,
		PFW_KEY_ARMED = 3'h4
	} pfw_key_type;

endpackage

// File: bench/pfw_flash_model.sv
// Behavioural flash array with user and trim areas
`timescale 1ns/1ps
module pfw_flash_model (
	// Controller side
	input wire logic hclk,
	input wire logic rd,
	input wire logic trim,
	input wire logic erase,
	input wire logic wr,
	input wire logic [11:0] addr,
	input wire logic [13:0] wdata,
	output logic [13:0] rdata
);
	logic [13:0] mem [4096];
	logic [13:0] trim_mem [16];
	logic [13:0] word;

	assign word = trim ? trim_mem[addr[3:0]] : mem[addr];
	// Valid only while the read pulse stands
	assign rdata = rd ? word : ~word;

	always @(posedge hclk) begin
		if (erase) begin
			for (int i = 0; i < 16; i++) mem[{addr[11:4], i[3:0]}] <= 14'h3FFF;
		end
		if (wr) mem[addr] <= wdata;
	end
endmodule

// File: bench/pfw_ctrl_checker.sv
// Port assertions for the flash self-write controller
`timescale 1ns/1ps
module pfw_ctrl_checker #(
	parameter int unsigned ADDR_W = 12,
	parameter int unsigned PWRUP_CYCLES = 20,
	parameter int unsigned WRITE_CYCLES = 10
) (
	// Clock, reset and bus answer
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	// Flash and core side
	input wire logic flash_rd,
	input wire logic flash_trim_space,
	input wire logic flash_erase,
	input wire logic flash_wr,
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic cpu_skip,
	input wire logic cpu_stall
);
	int unsigned up_cnt;
	int unsigned stall_cnt;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Cycles since release and length of the current stall
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			up_cnt <= 0;
			stall_cnt <= 0;
		end else begin
			if (up_cnt < PWRUP_CYCLES) up_cnt <= up_cnt + 1;
			stall_cnt <= cpu_stall ? stall_cnt + 1 : 0;
		end
	end

	sequence s_commit;
		flash_wr [*4] ##1 !flash_wr;
	endsequence

	chk_bus_ready_okay: assert property ($past(hresetn) |-> hreadyout && !hresp) else $error("bus answer wrong");
	chk_read_one_cycle: assert property (flash_rd |-> cpu_skip ##1 !flash_rd) else $error("read pulse wrong");
	chk_commit_burst: assert property ($rose(cpu_stall) && !flash_erase |-> !flash_wr ##1 s_commit)
		else $error("commit burst wrong");
	chk_erase_row: assert property (flash_erase |-> cpu_stall && flash_addr[3:0] == 4'h0 ##1 !flash_wr ##1 s_commit)
		else $error("erase wrong");
	chk_block_base: assert property ($rose(flash_wr) && cpu_stall |-> flash_addr[1:0] == 2'h0) else $error("block base wrong");
	chk_block_order: assert property (flash_wr && $past(flash_wr) |-> flash_addr == $past(flash_addr) + 1'b1) else $error("word order wrong");
	chk_stall_length: assert property ($fell(cpu_stall) |-> stall_cnt >= WRITE_CYCLES) else $error("stall too short");
	chk_pwrup_guard: assert property (up_cnt < PWRUP_CYCLES |-> !cpu_stall) else $error("write during power-up");
	chk_trim_no_write: assert property (flash_trim_space |-> !flash_wr && !flash_erase) else $error("write in trim space");
	cov_commit: cover property ($rose(cpu_stall));
endmodule

bind pfw_ctrl pfw_ctrl_checker #(.ADDR_W(ADDR_W), .PWRUP_CYCLES(PWRUP_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) pfw_ctrl_checker_i (
	.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .flash_rd(flash_rd),
	.flash_trim_space(flash_trim_space), .flash_erase(flash_erase), .flash_wr(flash_wr),
	.flash_addr(flash_addr), .cpu_skip(cpu_skip), .cpu_stall(cpu_stall)
);

// File: bench/pfw_ctrl_tb.sv
// Self-checking bench for the flash self-write controller
`timescale 1ns/1ps
`include "pfw_regs.svh"
module pfw_ctrl_tb;
	logic hclk, hresetn, hwrite, hready, hreadyout, hresp, code_protect, ext_prog_wr;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans, guard;
	logic [11:0] ext_prog_addr, flash_addr;
	logic [13:0] ext_prog_data, flash_wdata, flash_rdata;
	logic flash_rd, flash_trim_space, flash_erase, flash_wr, cpu_skip, cpu_stall;
	int fail_count, compares, cycles, wr_count, erase_count;
	logic [7:0] ofs [4] = '{`PFW_OFS_DATA_LOW, `PFW_OFS_DATA_HIGH, `PFW_OFS_ADDR_LOW, `PFW_OFS_ADDR_HIGH};
	logic [7:0] msk [4] = '{8'hFF, 8'h3F, 8'hFF, 8'h0F};
	int kk [5] = '{0, 1, 2, 1, 1};
	logic [7:0] cc [5] = '{8'h06, 8'h02, 8'h06, 8'h46, 8'h06};
	logic [1:0] gg [5] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h0};

	assign hready = hreadyout;

	pfw_ctrl #(.PWRUP_CYCLES(20), .WRITE_CYCLES(10)) pfw_ctrl_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(`PFW_HSIZE_WORD), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .block_guard_bits(guard), .code_protect(code_protect), .ext_prog_wr(ext_prog_wr),
		.ext_prog_addr(ext_prog_addr), .ext_prog_data(ext_prog_data), .flash_rd(flash_rd),
		.flash_trim_space(flash_trim_space), .flash_erase(flash_erase), .flash_wr(flash_wr),
		.flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
		.cpu_skip(cpu_skip), .cpu_stall(cpu_stall)
	);

	pfw_flash_model pfw_flash_model_i (
		.hclk(hclk), .rd(flash_rd), .trim(flash_trim_space), .erase(flash_erase), .wr(flash_wr),
		.addr(flash_addr), .wdata(flash_wdata), .rdata(flash_rdata)
	);

	// Clock
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	// Cycle ceiling and flash strobe counts
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (flash_wr) wr_count <= wr_count + 1;
		if (flash_erase) erase_count <= erase_count + 1;
		if (cycles == 3000) begin
			fail_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One single word transfer, address phase then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask

	// Write then one idle edge so a following read sees it
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d}, q);
		@(posedge hclk);
	endtask

	task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 32'h0, q);
		chk(q, {24'h0, e});
	endtask

	task automatic strobe(input int k, input logic [7:0] c);
		if (k > 0) bus(1'b1, `PFW_OFS_UNLOCK, {24'h0, `PFW_KEY_FIRST}, q);
		if (k == 2) bus(1'b1, `PFW_OFS_DATA_HIGH, 32'h0, q);
		if (k > 0) bus(1'b1, `PFW_OFS_UNLOCK, {24'h0, `PFW_KEY_SECOND}, q);
		reg_wr(`PFW_OFS_CONTROL, c);
	endtask

	task automatic put_word(input logic [11:0] a, input logic [13:0] d, input int k, input logic [7:0] c);
		reg_wr(`PFW_OFS_ADDR_LOW, a[7:0]);
		reg_wr(`PFW_OFS_ADDR_HIGH, {4'h0, a[11:8]});
		reg_wr(`PFW_OFS_DATA_LOW, d[7:0]);
		reg_wr(`PFW_OFS_DATA_HIGH, {2'h0, d[13:8]});
		strobe(k, c);
	endtask

	task automatic do_read(input logic [11:0] a, input logic [7:0] c, input logic [13:0] d);
		reg_wr(`PFW_OFS_ADDR_LOW, a[7:0]);
		reg_wr(`PFW_OFS_ADDR_HIGH, {4'h0, a[11:8]});
		bus(1'b1, `PFW_OFS_CONTROL, {24'h0, c}, q);
		#1 chk(cpu_skip, 1'b0);
		@(posedge hclk);
		#1 chk({flash_rd, cpu_skip, flash_trim_space}, {2'h3, c[6]});
		repeat (3) @(posedge hclk);
		reg_chk(`PFW_OFS_DATA_LOW, d[7:0]);
		reg_chk(`PFW_OFS_DATA_HIGH, {2'h0, d[13:8]});
		reg_chk(`PFW_OFS_CONTROL, c & 8'h40);
	endtask

	// Main sequence
	initial begin
		hresetn = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		guard = 2'h3;
		code_protect = 1'b0;
		ext_prog_wr = 1'b0;
		ext_prog_addr = 12'h0;
		ext_prog_data = 14'h0;
		fail_count = 0;
		compares = 0;
		cycles = 0;
		wr_count = 0;
		erase_count = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		reg_chk(`PFW_OFS_CONTROL, 8'h00);
		strobe(1, 8'h06);
		reg_chk(`PFW_OFS_CONTROL, 8'h04);
		reg_chk(`PFW_OFS_STATUS, 8'h05);
		bus(1'b0, `PFW_OFS_STATUS, 32'h0, q);
		while (q[0] !== 1'b0) bus(1'b0, `PFW_OFS_STATUS, 32'h0, q);
		for (int i = 0; i < 4; i++) begin
			reg_chk(ofs[i], 8'h00);
			reg_wr(ofs[i], 8'hFF);
			reg_chk(ofs[i], msk[i]);
		end
		reg_wr(`PFW_OFS_CONTROL, 8'hB8);
		reg_chk(`PFW_OFS_CONTROL, 8'h00);
		reg_wr(`PFW_OFS_UNLOCK, `PFW_KEY_FIRST);
		reg_chk(`PFW_OFS_UNLOCK, 8'h00);
		reg_chk(8'h40, 8'h00);
		pfw_flash_model_i.mem[12'h123] = 14'h2A5C;
		pfw_flash_model_i.trim_mem[5] = 14'h1234;
		pfw_flash_model_i.mem[12'h04C] = 14'h1111;
		do_read(12'h123, 8'h01, 14'h2A5C);
		do_read(12'h005, 8'h41, 14'h1234);
		// every buffer entry, in address order
		for (int b = 0; b < 2; b++) begin
			for (int w = 0; w < 4; w++) begin
				put_word(12'h040 + 4 * b + w, 14'h2A00 + 4 * b + w, 1, 8'h06);
				#1 chk(cpu_stall, 1'b0);
				if (w == 3) begin
					@(posedge hclk);
					#1 chk(cpu_stall, 1'b1);
					while (cpu_stall !== 1'b0) @(posedge hclk);
				end
				reg_chk(`PFW_OFS_CONTROL, 8'h04);
			end
			chk(erase_count, 1);
		end
		for (int i = 0; i < 8; i++) chk(pfw_flash_model_i.mem[12'h040 + i], 14'h2A00 + i);
		chk(pfw_flash_model_i.mem[12'h04C], 14'h3FFF);
		chk(wr_count, 8);
		for (int i = 0; i < 5; i++) begin
			guard <= gg[i];
			put_word(12'h053, 14'h0, kk[i], cc[i]);
			reg_chk(`PFW_OFS_CONTROL, cc[i] & 8'h44);
			reg_chk(`PFW_OFS_STATUS, 8'h04);
		end
		chk(wr_count, 8);
		reg_wr(`PFW_OFS_CONTROL, 8'h00);
		for (int i = 0; i < 2; i++) begin
			code_protect <= i[0];
			ext_prog_addr <= 12'h060;
			ext_prog_data <= 14'h0ABC + i;
			ext_prog_wr <= 1'b1;
			@(posedge hclk);
			ext_prog_wr <= 1'b0;
			repeat (20) @(posedge hclk);
			chk(pfw_flash_model_i.mem[12'h060], 14'h0ABC);
		end
		stop_test();
	end
endmodule
